// ---- hw/pft_pkg.sv ----
// package for the pause frame timer and refresh block
package pft_pkg;
    // byte addresses of the two registers (printed offsets are word aligned)
    localparam logic [15:0] PFT_ADDR_PAUSE_TIME = 16'h0170;
    localparam logic [15:0] PFT_ADDR_REFRESH = 16'h5f40;
    // field layout
    localparam int PFT_FIELD_MSB = 15;
    localparam int PFT_FIELD_W = 16;
    // reset values (undefined in hardware; zero chosen here)
    localparam logic [15:0] PFT_PAUSE_TIME_RST = 16'h0000;
    localparam logic [15:0] PFT_REFRESH_RST = 16'h0000;
    // slot length in byte times
    localparam int PFT_SLOT_BYTES = 64;
    // zero-filled upper half of every register word
    localparam logic [15:0] PFT_UPPER_ZERO = 16'h0000;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } pft_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pft_apb_rsp_t;

    typedef enum logic [1:0] {
        PFT_IDLE,
        PFT_PAUSED
    } pft_state_t;

    typedef struct packed {
        pft_state_t st;
        logic [15:0] pause_time_field;
        logic [15:0] refresh_threshold_field;
        logic [15:0] refresh_count;
        logic [5:0] byte_count;
        logic xoff_req;
        logic [31:0] prdata;
        logic pslverr;
    } pft_state_all_t;
endpackage : pft_pkg

// ---- hw/pft_pause_timer.sv ----
// transmit flow-control pause time and xoff refresh timer with apb registers
//
// Overview of operation
// R01: xoff frames carry programmed 16-bit pause time
// R02: software pause frames use programmed pause time
// R03: pause units are slots of 64 byte times
// R04: software sets pause time zero for xon
// R05: counter at threshold while congested resends xoff
// R06: refresh counter advances once per slot
// R07: threshold zero disables refresh entirely
// R08: upper sixteen bits read zero, write zero
// R09: counter restarts on xoff, cleared when idle
//
// register map (32-bit words, fields in bits 15:0, upper half reads zero)
//   pause_time_value        pause time for xoff and software pause frames
//   pause_refresh_threshold slots between refresh xoff frames, zero disables
//
// interface summary
//   apb answers with no wait states: read data is loaded in the setup cycle
//   and shown in the access cycle; writes land at the end of the access cycle
//   unmapped addresses answer with pslverr, writes to them are dropped
//   byte_tick marks one transmitted byte time; 64 of them make one slot
//   rx_above_high starts a pause, rx_above_low keeps it going
//   xoff_req repeats every cycle at threshold until xoff_sent is seen
//
// ports
//   apb_req, apb_rsp   register bus, byte addresses, one word per register
//   byte_tick          one pulse per transmitted byte time
//   rx_above_high      receive buffer above its high threshold
//   rx_above_low       receive buffer above its low threshold
//   xoff_sent          the transmitter has just sent an xoff frame
//   pause_time_field   pause quantum for every xoff and software pause frame
//   xoff_req           asks the transmitter for a refresh xoff frame
//
// reset
//   both fields clear to zero; their power-up value is otherwise undefined
//   pready is high during and after reset
//
// limitations
//   the slot counter runs free, so the first slot of a pause may be short
//   the pause time itself is only carried to the frame builder, not counted
`timescale 1ns/10ps
`default_nettype none

module pft_pause_timer
    import pft_pkg::*;
#(
    parameter int SLOT_BYTES = PFT_SLOT_BYTES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire pft_apb_req_t apb_req,
    output pft_apb_rsp_t apb_rsp,
    input wire logic byte_tick,
    input wire logic rx_above_high,
    input wire logic rx_above_low,
    input wire logic xoff_sent,
    output logic [15:0] pause_time_field,
    output logic xoff_req
);
    // slot length is fixed; a power of two keeps the byte counter a simple wrap
    if (SLOT_BYTES != 64) begin : g_bad_slot
        $error("pft_pause_timer: slot length must be 64 byte times");
    end
    // the package must describe the same 16-bit field the logic was built around
    if (PFT_FIELD_W != 16) begin : g_bad_field_w
        $error("pft_pause_timer: register fields must be 16 bits wide");
    end
    if (PFT_FIELD_MSB != PFT_FIELD_W - 1) begin : g_bad_field_msb
        $error("pft_pause_timer: field msb must match the field width");
    end
    // both registers take one aligned 32-bit word each
    if (PFT_ADDR_PAUSE_TIME[1:0] != 2'b00) begin : g_bad_addr_pause
        $error("pft_pause_timer: pause time address must be word aligned");
    end
    if (PFT_ADDR_REFRESH[1:0] != 2'b00) begin : g_bad_addr_refresh
        $error("pft_pause_timer: refresh threshold address must be word aligned");
    end
    if (PFT_ADDR_PAUSE_TIME == PFT_ADDR_REFRESH) begin : g_bad_addr_clash
        $error("pft_pause_timer: the two registers need distinct addresses");
    end

    // last byte time of a slot, and the width of the byte counter
    localparam int BYTE_CNT_W = $clog2(SLOT_BYTES);
    localparam logic [5:0] SLOT_LAST = 6'(SLOT_BYTES - 1);
    if (BYTE_CNT_W != 6) begin : g_bad_byte_cnt
        $error("pft_pause_timer: byte counter is built six bits wide");
    end

    // state registers and bus phase decode
    pft_state_all_t q;
    pft_state_all_t next_q;
    logic setup;
    logic access;
    logic wr_access;
    logic hit_pause_time;
    logic hit_refresh;
    logic hit_none;
    logic [31:0] rd_word;
    logic slot_tick;
    logic at_threshold;
    logic refresh_on;

    assign setup = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable;
    assign wr_access = access & apb_req.pwrite;

    // address decode; anything outside the two words answers with an error
    always_comb begin
        hit_pause_time = 1'b0;
        hit_refresh = 1'b0;
        hit_none = 1'b0;
        if (apb_req.paddr == PFT_ADDR_PAUSE_TIME) begin
            hit_pause_time = 1'b1;
        end else if (apb_req.paddr == PFT_ADDR_REFRESH) begin
            hit_refresh = 1'b1;
        end else begin
            hit_none = 1'b1;
        end
    end

    // read word; the reserved upper half is a constant zero, not stored
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_pause_time) begin
            rd_word = {PFT_UPPER_ZERO, q.pause_time_field}; // R08
        end else if (hit_refresh) begin
            rd_word = {PFT_UPPER_ZERO, q.refresh_threshold_field}; // R08
        end
    end

    // slot ends on the 64th byte time
    assign slot_tick = byte_tick & (q.byte_count == SLOT_LAST); // R03 R06
    // a zero threshold switches the refresh off altogether
    assign refresh_on = (q.refresh_threshold_field != 16'h0000); // R07
    assign at_threshold = (q.refresh_count == q.refresh_threshold_field); // R05

    always_comb begin
        next_q = q;
        next_q.pslverr = 1'b0;
        next_q.xoff_req = 1'b0;

        // register access: setup cycle prepares read data, access cycle commits
        if (setup) begin
            next_q.prdata = rd_word; // R08
            next_q.pslverr = hit_none;
        end
        if (wr_access) begin
            // upper bits are dropped so they always read back zero
            if (hit_pause_time) begin
                next_q.pause_time_field = apb_req.pwdata[PFT_FIELD_MSB:0]; // R01 R02 R04 R08
            end else if (hit_refresh) begin
                next_q.refresh_threshold_field = apb_req.pwdata[PFT_FIELD_MSB:0]; // R08
            end
        end

        // free-running byte counter; slots are not aligned to pause entry
        if (byte_tick) begin
            next_q.byte_count = q.byte_count + 6'h01; // R03
        end

        case (q.st)
            PFT_IDLE: begin
                // counter is parked at zero outside a pause
                next_q.refresh_count = 16'h0000; // R09
                // a pause begins only at the high mark
                if (rx_above_high) begin
                    next_q.st = PFT_PAUSED;
                end
            end
            PFT_PAUSED: begin
                if (!rx_above_low) begin
                    // congestion has cleared: no more refresh frames
                    next_q.st = PFT_IDLE;
                    next_q.refresh_count = 16'h0000; // R09
                end else if (xoff_sent) begin
                    // any xoff on the wire restarts the refresh interval
                    next_q.refresh_count = 16'h0000; // R09
                end else if (refresh_on) begin // R07
                    if (at_threshold) begin
                        // held until the frame goes out; the count waits here
                        next_q.xoff_req = 1'b1; // R05
                    end else if (slot_tick) begin
                        next_q.refresh_count = q.refresh_count + 16'h0001; // R06
                    end
                end
            end
            default: begin
                next_q.st = PFT_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{
                st: PFT_IDLE,
                pause_time_field: PFT_PAUSE_TIME_RST,
                refresh_threshold_field: PFT_REFRESH_RST,
                refresh_count: 16'h0000,
                byte_count: 6'h00,
                xoff_req: 1'b0,
                prdata: 32'h0000_0000,
                pslverr: 1'b0
            };
        end else begin
            q <= next_q;
        end
    end

    // zero wait states: data prepared in setup, presented in access
    // pready stays high so a stray access can never stall the bus
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.prdata = q.prdata;
    assign apb_rsp.pslverr = q.pslverr & access;
    assign pause_time_field = q.pause_time_field; // R01 R02
    assign xoff_req = q.xoff_req; // R05
endmodule : pft_pause_timer

`default_nettype wire

// ---- dv/pft_pause_timer_asserts.sv ----
// port checker for the pause timer
`timescale 1ns/10ps
`default_nettype none
module pft_chk import pft_pkg::*; (input wire logic pclk, input wire logic presetn,
    input wire pft_apb_req_t apb_req, input wire pft_apb_rsp_t apb_rsp,
    input wire logic rx_above_low, input wire logic [15:0] pause_time_field,
    input wire logic xoff_req);
    default clocking @(posedge pclk); endclocking default disable iff (!presetn);
    wire ac = apb_req.psel && apb_req.penable;
    wire wr = ac && apb_req.pwrite && apb_req.paddr == PFT_ADDR_PAUSE_TIME;
    property p_rd; ac |-> apb_rsp.prdata[31:16] == 16'h0000; endproperty
    a_rd: assert property (p_rd) else $error("upper half set");
    property p_wr; wr |=> pause_time_field == $past(apb_req.pwdata[15:0]); endproperty
    a_wr: assert property (p_wr) else $error("pause time lost");
    property p_lo; !rx_above_low [*2] |=> !xoff_req; endproperty
    a_lo: assert property (p_lo) else $error("refresh outside pause");
    wire mapped = apb_req.paddr == PFT_ADDR_PAUSE_TIME || apb_req.paddr == PFT_ADDR_REFRESH;
    wire rdp = ac && !apb_req.pwrite && apb_req.paddr == PFT_ADDR_PAUSE_TIME;
    property p_rv; rdp |-> apb_rsp.prdata[15:0] == pause_time_field; endproperty
    a_rv: assert property (p_rv) else $error("pause time read wrong");
    property p_err; ac |-> apb_rsp.pslverr == !mapped; endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    property p_hold; !wr |=> $stable(pause_time_field); endproperty
    a_hold: assert property (p_hold) else $error("pause time changed unasked");
    c_w: cover property (wr); c_x: cover property (xoff_req); c_e: cover property (apb_rsp.pslverr);
endmodule : pft_chk
bind pft_pause_timer pft_chk u_chk(.*);
`default_nettype wire

// ---- dv/pft_link.sv ----
// link partner model: sends the xoff a few cycles after each request
`timescale 1ns/10ps
`default_nettype none
module pft_link (input wire logic pclk, input wire logic presetn, input wire logic xoff_req,
    output logic byte_tick, output logic xoff_sent);
    logic [2:0] d;
    // link kept busy, so every cycle is one byte time
    assign byte_tick = 1'b1;
    assign xoff_sent = d == 3'h1;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) d <= 3'h0;
        else d <= (xoff_req && d == 3'h0) ? 3'h5 : d - 3'(d != 3'h0);
endmodule : pft_link
`default_nettype wire

// ---- dv/pft_pause_timer_bench.sv ----
// bench for the pause timer block
`timescale 1ns/10ps
`default_nettype none
module pft_pause_timer_bench import pft_pkg::*; ;
    logic pclk = 1'b0, presetn = 1'b0, hi = 1'b0, lo = 1'b0;
    pft_apb_req_t rq = '0;
    pft_apb_rsp_t rs;
    wire byte_tick, xoff_sent, xr;
    wire [15:0] pause_time_field;
    int bad_count = 0, n_tests = 0, k;
    always #20 pclk = ~pclk;
    pft_pause_timer u_dut(.pclk(pclk), .presetn(presetn), .apb_req(rq), .apb_rsp(rs),
        .byte_tick(byte_tick), .rx_above_high(hi), .rx_above_low(lo), .xoff_sent(xoff_sent),
        .pause_time_field(pause_time_field), .xoff_req(xr));
    pft_link u_link(.pclk(pclk), .presetn(presetn), .xoff_req(xr), .byte_tick(byte_tick),
        .xoff_sent(xoff_sent));
    task chk(input logic c);
        n_tests++; if (!c) begin bad_count++; $display("MISMATCH %0t wrong value", $time); end
    endtask : chk
    // reads pass the expected word in d
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        rq <= '{1'b1, 1'b0, w, a, w ? d : 32'h0};
        @(posedge pclk) rq.penable <= 1'b1;
        do @(posedge pclk); while (rs.pready !== 1'b1);
        if (!w) chk(rs.prdata === d);
        chk(rs.pslverr === (a != PFT_ADDR_PAUSE_TIME && a != PFT_ADDR_REFRESH));
        rq <= '0;
        @(posedge pclk);
    endtask : apb
    task enter(input logic [31:0] t);
        apb(1, PFT_ADDR_REFRESH, t);
        {lo, hi} <= 2'b11;
        @(posedge pclk) hi <= 1'b0;
    endtask : enter
    task t_regs;
        apb(0, PFT_ADDR_REFRESH, 32'h0);
        apb(1, PFT_ADDR_PAUSE_TIME, 32'hffffa5c3);
        apb(0, PFT_ADDR_PAUSE_TIME, 32'h0000a5c3);
        chk(pause_time_field === 16'ha5c3);
        apb(1, 16'h0174, 32'h1);
    endtask : t_regs
    task t_refresh;
        apb(1, PFT_ADDR_PAUSE_TIME, 32'h0);
        chk(pause_time_field === 16'h0000);
        enter(32'h2);
        wait (xoff_sent === 1'b1);
        // skip the request pulses still in flight when the send lands
        repeat (3) @(posedge pclk);
        for (k = 0; xr !== 1'b1; k++) @(posedge pclk);
        chk(k >= 60 && k <= 135);
        lo <= 1'b0;
        enter(32'h0);
        repeat (300) @(posedge pclk) chk(xr === 1'b0);
    endtask : t_refresh
    task wrap_up;
        $display("mismatches %0d checks %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_refresh;
        wrap_up;
    end
    initial begin
        #100us;
        bad_count++;
        wrap_up;
    end
endmodule : pft_pause_timer_bench
`default_nettype wire
